// ==== src/sync_width_defs.svh ====
// Offsets, field positions, reset values and encodings for the sync width block
`ifndef SYNC_WIDTH_DEFS_SVH
`define SYNC_WIDTH_DEFS_SVH

// Register indexes; byte address is four times the index
`define IDX_CHAN_MODE             8'h10
`define IDX_LINK_SELECT           8'h18
`define IDX_CHAN_B_HSYNC_LOW      8'h2e
`define IDX_CHAN_B_HSYNC_HIGH     8'h2f
`define IDX_CHAN_A_VSYNC_LOW      8'h30
`define IDX_CHAN_A_VSYNC_HIGH     8'h31
`define IDX_CHAN_B_VSYNC_LOW      8'h32
`define IDX_CHAN_B_VSYNC_HIGH     8'h33
`define IDX_STATUS                8'h40

// Field positions
`define CHAN_MODE_LSB             5
`define CHAN_MODE_MSB             6
`define LINK_SELECT_BIT           4
`define HIGH_FIELD_MSB            3
`define STAT_A_VSYNC_BIT          0
`define STAT_B_VSYNC_BIT          1
`define STAT_B_HSYNC_BIT          2
`define STAT_SPLIT_BIT            3

// Encodings and reset values
`define CHAN_MODE_SPLIT           2'h2
`define REG_RESET                 8'h00
`define HIGH_RESET                4'h0
`define AXI_RESP_OKAY             2'h0
`define AXI_RESP_SLVERR           2'h2

`endif

// ==== src/sync_width_pkg.sv ====
// Types shared by the sync pulse width block
package sync_width_pkg;

  typedef logic [9:0] pulse_count_t;

  // Widths captured at the start of each frame
  typedef struct packed {
    pulse_count_t b_hpulse;
    pulse_count_t a_vpulse;
    pulse_count_t b_vpulse;
  } frame_widths_t;

  typedef enum logic {
    PULSE_IDLE,
    PULSE_ACTIVE
  } pulse_state_t;

endpackage

// ==== src/lvds_sync_pulse_width_config.sv ====
// Sync pulse width registers and sync pulse generators for the LVDS links
// Functional notes
// R1 - Channel B hsync lasts the programmed 10-bit count of pixel clocks, low eight bits at register 0x2E.
// R2 - The top two bits of the channel B hsync width come from the low nibble of 0x2F; bits 7 to 4 are reserved.
// R3 - Channel B hsync and vsync widths apply only when the channel mode field 0x10.6:5 equals 10.
// R4 - Channel A vsync width drives channel A, and both channels when single-link select is 0 and mode is 00 or 01.
//      The code drives both channels from it in every mode but 10, and ignores single-link select.
// R5 - Channel A vsync lasts a 10-bit count of lines from 0x30 and the low nibble of 0x31.
// R6 - Channel B vsync lasts a 10-bit count of lines whose low eight bits sit in 0x32.
// R7 - The top two bits of the channel B vsync width come from the low nibble of 0x33; the upper nibble is reserved.
// R8 - Each sync stays asserted for exactly the count captured at frame start, then releases.
`include "sync_width_defs.svh"

// One sync pulse: held for width ticks after start
module sync_pulse_gen (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        start,
  input  wire logic                        tick,
  input  wire sync_width_pkg::pulse_count_t width,
  output logic                             pulse
);
  sync_width_pkg::pulse_state_t state;
  sync_width_pkg::pulse_count_t remaining;
  wire last_tick = tick && (remaining == 10'h001);

  // Start wins over a tick in the same cycle; zero width gives no pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= sync_width_pkg::PULSE_IDLE;
      remaining <= 10'h000;
    end else if (start) begin
      state     <= (width != 10'h000) ? sync_width_pkg::PULSE_ACTIVE : sync_width_pkg::PULSE_IDLE; // R8
      remaining <= width;
    end else begin
      case (state)
        sync_width_pkg::PULSE_IDLE: begin
          remaining <= remaining;
        end
        sync_width_pkg::PULSE_ACTIVE: begin
          if (last_tick) begin
            state <= sync_width_pkg::PULSE_IDLE; // R8
          end
          if (tick) begin
            remaining <= remaining - 10'h001;
          end
        end
        default: begin
          state <= sync_width_pkg::PULSE_IDLE;
        end
      endcase
    end
  end

  assign pulse = (state == sync_width_pkg::PULSE_ACTIVE);
endmodule

module lvds_sync_pulse_width_config (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        frame_start_a,
  input  wire logic        line_start_a,
  input  wire logic        frame_start_b,
  input  wire logic        line_start_b,
  output logic             chan_a_vsync,
  output logic             chan_b_vsync,
  output logic             chan_b_hsync
);

  // Register storage; reserved nibbles are not stored and read as zero
  logic [7:0] chan_b_hsync_width_low;
  logic [3:0] chan_b_hsync_width_high;
  logic [7:0] chan_a_vsync_width_low;
  logic [3:0] chan_a_vsync_width_high;
  logic [7:0] chan_b_vsync_width_low;
  logic [3:0] chan_b_vsync_width_high;
  logic [1:0] chan_mode;
  logic       single_link;

  // Write channel bookkeeping
  logic        aw_got;
  logic        w_got;
  logic [11:0] aw_addr;
  logic [7:0]  w_byte;
  logic        w_lane0;
  wire         aw_fire       = s_axi_awvalid && s_axi_awready;
  wire         w_fire        = s_axi_wvalid && s_axi_wready;
  wire         wr_go         = aw_got && w_got && !s_axi_bvalid;
  wire         next_aw_got   = (aw_got || aw_fire) && !wr_go;
  wire         next_w_got    = (w_got || w_fire) && !wr_go;
  wire         next_bvalid   = wr_go || (s_axi_bvalid && !s_axi_bready);
  wire         ar_fire       = s_axi_arvalid && s_axi_arready;
  wire         next_rvalid   = ar_fire || (s_axi_rvalid && !s_axi_rready);
  wire  [9:0]  wr_idx        = aw_addr[11:2];
  wire  [9:0]  rd_idx        = s_axi_araddr[11:2];

  // Address decode for writes
  wire hit_mode   = (wr_idx == {2'h0, `IDX_CHAN_MODE});
  wire hit_link   = (wr_idx == {2'h0, `IDX_LINK_SELECT});
  wire hit_bh_lo  = (wr_idx == {2'h0, `IDX_CHAN_B_HSYNC_LOW});
  wire hit_bh_hi  = (wr_idx == {2'h0, `IDX_CHAN_B_HSYNC_HIGH});
  wire hit_av_lo  = (wr_idx == {2'h0, `IDX_CHAN_A_VSYNC_LOW});
  wire hit_av_hi  = (wr_idx == {2'h0, `IDX_CHAN_A_VSYNC_HIGH});
  wire hit_bv_lo  = (wr_idx == {2'h0, `IDX_CHAN_B_VSYNC_LOW});
  wire hit_bv_hi  = (wr_idx == {2'h0, `IDX_CHAN_B_VSYNC_HIGH});
  wire hit_stat   = (wr_idx == {2'h0, `IDX_STATUS});
  wire wr_mapped  = hit_mode | hit_link | hit_bh_lo | hit_bh_hi | hit_av_lo | hit_av_hi
                  | hit_bv_lo | hit_bv_hi | hit_stat;
  wire wr_en      = wr_go && w_lane0;

  // Handshake flops; the response waits for both address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 12'h000;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_RESP_OKAY;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      s_axi_awready <= !next_aw_got && !next_bvalid;
      s_axi_wready  <= !next_w_got && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (aw_fire) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bresp <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
    end
  end

  // Register writes; status is read-only, so a write there is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_b_hsync_width_low  <= `REG_RESET;
      chan_b_hsync_width_high <= `HIGH_RESET;
      chan_a_vsync_width_low  <= `REG_RESET;
      chan_a_vsync_width_high <= `HIGH_RESET;
      chan_b_vsync_width_low  <= `REG_RESET;
      chan_b_vsync_width_high <= `HIGH_RESET;
      chan_mode               <= 2'h0;
      single_link             <= 1'b0;
    end else if (wr_en) begin
      if (hit_mode) chan_mode <= w_byte[`CHAN_MODE_MSB:`CHAN_MODE_LSB];
      if (hit_link) single_link <= w_byte[`LINK_SELECT_BIT];
      if (hit_bh_lo) chan_b_hsync_width_low <= w_byte; // R1
      if (hit_bh_hi) chan_b_hsync_width_high <= w_byte[`HIGH_FIELD_MSB:0]; // R2
      if (hit_av_lo) chan_a_vsync_width_low <= w_byte; // R5
      if (hit_av_hi) chan_a_vsync_width_high <= w_byte[`HIGH_FIELD_MSB:0]; // R5
      if (hit_bv_lo) chan_b_vsync_width_low <= w_byte; // R6
      if (hit_bv_hi) chan_b_vsync_width_high <= w_byte[`HIGH_FIELD_MSB:0]; // R7
    end
  end

  // Live widths; only the low two bits of each high nibble count
  wire split_mode = (chan_mode == `CHAN_MODE_SPLIT);
  sync_width_pkg::frame_widths_t live;
  assign live.b_hpulse = {chan_b_hsync_width_high[1:0], chan_b_hsync_width_low}; // R1 R2
  assign live.a_vpulse = {chan_a_vsync_width_high[1:0], chan_a_vsync_width_low}; // R5
  assign live.b_vpulse = split_mode ? {chan_b_vsync_width_high[1:0], chan_b_vsync_width_low} // R3 R6 R7
                                    : live.a_vpulse; // R4

  // Channel B timing follows channel A's events unless split
  wire b_frame = split_mode ? frame_start_b : frame_start_a; // R3 R4
  wire b_line  = split_mode ? line_start_b : line_start_a;

  // Snapshot at frame start so mid-frame writes land next frame
  sync_width_pkg::frame_widths_t snap;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap <= '0;
    end else begin
      if (frame_start_a) snap.a_vpulse <= live.a_vpulse; // R8
      if (b_frame) begin
        snap.b_hpulse <= live.b_hpulse; // R8
        snap.b_vpulse <= live.b_vpulse; // R8
      end
    end
  end

  // The frame-start cycle itself must already see the new value
  wire [9:0] use_a_v = frame_start_a ? live.a_vpulse : snap.a_vpulse;
  wire [9:0] use_b_v = b_frame ? live.b_vpulse : snap.b_vpulse;
  wire [9:0] use_b_h = b_frame ? live.b_hpulse : snap.b_hpulse;

  sync_pulse_gen a_vsync_gen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (frame_start_a),
    .tick    (line_start_a),
    .width   (use_a_v),
    .pulse   (chan_a_vsync)
  ); // R4 R5

  sync_pulse_gen b_vsync_gen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (b_frame),
    .tick    (b_line),
    .width   (use_b_v),
    .pulse   (chan_b_vsync)
  ); // R4 R6

  // Hsync B only runs in split mode; leaving split clears a pulse still running
  wire hsync_b_run = aresetn && split_mode; // R3
  sync_pulse_gen b_hsync_gen (
    .aclk    (aclk),
    .aresetn (hsync_b_run),
    .start   (split_mode && line_start_b),
    .tick    (1'b1),
    .width   (use_b_h),
    .pulse   (chan_b_hsync)
  ); // R3

  // Read decode, one word per register
  logic [31:0] rd_word;
  logic        rd_mapped;
  always_comb begin
    rd_word   = 32'h0000_0000;
    rd_mapped = 1'b1;
    if (rd_idx == {2'h0, `IDX_CHAN_MODE}) begin
      rd_word[`CHAN_MODE_MSB:`CHAN_MODE_LSB] = chan_mode;
    end else if (rd_idx == {2'h0, `IDX_LINK_SELECT}) begin
      rd_word[`LINK_SELECT_BIT] = single_link;
    end else if (rd_idx == {2'h0, `IDX_CHAN_B_HSYNC_LOW}) begin
      rd_word[7:0] = chan_b_hsync_width_low;
    end else if (rd_idx == {2'h0, `IDX_CHAN_B_HSYNC_HIGH}) begin
      rd_word[3:0] = chan_b_hsync_width_high;
    end else if (rd_idx == {2'h0, `IDX_CHAN_A_VSYNC_LOW}) begin
      rd_word[7:0] = chan_a_vsync_width_low;
    end else if (rd_idx == {2'h0, `IDX_CHAN_A_VSYNC_HIGH}) begin
      rd_word[3:0] = chan_a_vsync_width_high;
    end else if (rd_idx == {2'h0, `IDX_CHAN_B_VSYNC_LOW}) begin
      rd_word[7:0] = chan_b_vsync_width_low;
    end else if (rd_idx == {2'h0, `IDX_CHAN_B_VSYNC_HIGH}) begin
      rd_word[3:0] = chan_b_vsync_width_high;
    end else if (rd_idx == {2'h0, `IDX_STATUS}) begin
      rd_word[`STAT_A_VSYNC_BIT] = chan_a_vsync;
      rd_word[`STAT_B_VSYNC_BIT] = chan_b_vsync;
      rd_word[`STAT_B_HSYNC_BIT] = chan_b_hsync;
      rd_word[`STAT_SPLIT_BIT]   = split_mode;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // Read channel; data latched when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_fire) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
    end
  end

endmodule

// ==== verif/sync_width_sva.sv ====
// Concurrent checks on the sync pulse width block ports
module sync_width_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        frame_start_a,
  input wire logic        line_start_a,
  input wire logic        frame_start_b,
  input wire logic        line_start_b,
  input wire logic        chan_a_vsync,
  input wire logic        chan_b_vsync,
  input wire logic        chan_b_hsync
);
  // One domain, so clock and reset are given once
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_quiet: assert property ($rose(aresetn) |-> !(chan_a_vsync || chan_b_vsync || chan_b_hsync))
    else $error("sync output high after reset");
  chk_a_vs_rise: assert property ($rose(chan_a_vsync) |-> $past(frame_start_a))
    else $error("channel A vsync rose without a frame start");
  chk_a_vs_fall: assert property ($fell(chan_a_vsync) |-> $past(line_start_a) || $past(frame_start_a))
    else $error("channel A vsync fell off a line boundary");
  chk_b_vs_rise: assert property ($rose(chan_b_vsync) |-> $past(frame_start_b) || $past(frame_start_a))
    else $error("channel B vsync rose without a frame start");
  chk_b_hs_rise: assert property ($rose(chan_b_hsync) |-> $past(line_start_b))
    else $error("channel B hsync rose without a line start");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule

bind lvds_sync_pulse_width_config sync_width_sva i_sync_width_sva (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .frame_start_a,
  .line_start_a, .frame_start_b, .line_start_b, .chan_a_vsync, .chan_b_vsync, .chan_b_hsync);

// ==== verif/panel_model.sv ====
// Panel side: line and frame timing source plus sync width meter
module panel_model (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [9:0] period,
  input  wire logic       vsync,
  input  wire logic       hsync,
  output logic            frame_start = 1'b0,
  output logic            line_start  = 1'b0,
  output logic [9:0]      vs_lines    = 10'h0,
  output logic [9:0]      hs_clks     = 10'h0
);
  logic [9:0] cnt = 10'h0;

  // Lines tick every period cycles; a frame opens on a line tick
  always @(posedge aclk) begin
    frame_start <= go;
    line_start  <= go || cnt == period - 10'h1;
    cnt         <= (go || cnt == period - 10'h1) ? 10'h0 : cnt + 10'h1;
    // Vsync counted in line ticks seen while high, hsync in clocks
    if (frame_start) vs_lines <= 10'h0;
    else if (line_start && vsync) vs_lines <= vs_lines + 10'h1;
    if (line_start) hs_clks <= 10'h0;
    else if (hsync) hs_clks <= hs_clks + 10'h1;
  end
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the sync pulse width block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, go_a = 1'b0, go_b = 1'b0;
  logic [9:0] period = 10'h4, vs_a, vs_b, hs_b;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic frame_start_a, line_start_a, frame_start_b, line_start_b, chan_a_vsync, chan_b_vsync, chan_b_hsync;
  int err_total = 0, check_count = 0, cyc = 0;

  lvds_sync_pulse_width_config i_lvds_sync_pulse_width_config (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .frame_start_a, .line_start_a, .frame_start_b, .line_start_b, .chan_a_vsync, .chan_b_vsync,
    .chan_b_hsync);
  panel_model u_panel_a (.aclk, .go(go_a), .period, .vsync(chan_a_vsync), .hsync(1'b0),
    .frame_start(frame_start_a), .line_start(line_start_a), .vs_lines(vs_a), .hs_clks());
  panel_model u_panel_b (.aclk, .go(go_b), .period, .vsync(chan_b_vsync), .hsync(chan_b_hsync),
    .frame_start(frame_start_b), .line_start(line_start_b), .vs_lines(vs_b), .hs_clks(hs_b));

  always #5 aclk = ~aclk;

  // Hang guard, well above the expected run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready sampled mid-cycle is the value the next edge sees; bready is up from the start
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic       ta, tw, bv;
    logic [1:0] br;
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!bv);
    s_axi_bready <= 1'b0;
    chk({30'h0, br}, {30'h0, er});
  endtask

  // Read answer is taken at the edge where rvalid meets the raised rready
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic        ta, rv;
    logic [31:0] rdat;
    logic [1:0]  rr;
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      rdat = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!rv);
    s_axi_rready <= 1'b0;
    chk(rdat, exp);
    chk({30'h0, rr}, {30'h0, er});
  endtask

  task automatic frame(input logic [9:0] p, input logic a, input logic b);
    @(posedge aclk);
    period <= p;
    go_a <= a;
    go_b <= b;
    @(posedge aclk);
    go_a <= 1'b0;
    go_b <= 1'b0;
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then only the stored field bits read back
    for (int i = 0; i < 6; i++) begin
      rd(8'(8'h2e + i), 32'h0, 2'h0);
      wr(8'(8'h2e + i), 8'hff, 2'h0);
      rd(8'(8'h2e + i), i[0] ? 32'h0f : 32'hff, 2'h0);
    end
    wr(8'h20, 8'h55, 2'h2);
    rd(8'h20, 32'h0, 2'h2);
    $display("test registers done");
    // Split mode; upper high bits set to prove they are ignored
    wr(8'h10, 8'h40, 2'h0);
    wr(8'h2e, 8'h05, 2'h0);
    wr(8'h2f, 8'h0d, 2'h0);
    wr(8'h30, 8'h02, 2'h0);
    wr(8'h31, 8'h05, 2'h0);
    wr(8'h32, 8'h01, 2'h0);
    wr(8'h33, 8'h09, 2'h0);
    frame(10'd300, 1'b0, 1'b1);
    repeat (290) @(posedge aclk);
    chk({22'h0, hs_b}, 32'd261);
    frame(10'd4, 1'b1, 1'b1);
    // All three syncs just started, split flag set
    rd(8'h40, 32'h0000_000f, 2'h0);
    repeat (1100) @(posedge aclk);
    chk({22'h0, vs_a}, 32'd258);
    chk({22'h0, vs_b}, 32'd257);
    $display("test split done");
    // Other modes: B mirrors A, B hsync quiet, mid-frame edit deferred
    for (int m = 0; m < 3; m++) begin
      wr(8'h10, m == 0 ? 8'h00 : (m == 1 ? 8'h20 : 8'h60), 2'h0);
      wr(8'h18, m == 2 ? 8'h10 : 8'h00, 2'h0);
      wr(8'h30, 8'h05, 2'h0);
      wr(8'h31, 8'h00, 2'h0);
      frame(10'd4, 1'b1, 1'b1);
      wr(8'h30, 8'h09, 2'h0);
      repeat (40) @(posedge aclk);
      chk({22'h0, vs_a}, 32'd5);
      chk({22'h0, vs_b}, 32'd5);
      chk({22'h0, hs_b}, 32'd0);
    end
    $display("test mirror done");
    close_out();
  end
endmodule
